// [core/aux_code_defs.svh]
`ifndef AUX_CODE_DEFS_SVH
`define AUX_CODE_DEFS_SVH

// Code range
`define AUX_CODE_W        10
`define AUX_CODE_MAX      10'h3E7
`define AUX_INTERLOCK_MAX 10'h1F3
`define AUX_UPPER_MIN     10'h1F4
`define AUX_CODE_CLEAR    10'h000

// Fixed-point format of code values taken from registers or position data
`define AUX_VAL_IW        16
`define AUX_VAL_FW        8

// Host command word bits
`define CMD_FBE_BIT       4
`define CMD_ACK_BIT       6

// Task status word bits
`define TSW_ERR_BIT       0
`define TSW_AUTO_BIT      2
`define TSW_MANUAL_BIT    3
`define TSW_RUN_BIT       4
`define TSW_WAIT_ACK_BIT  7
`define TSW_STROBE_BIT    8

`endif

// [core/aux_code_pkg.sv]
`include "aux_code_defs.svh"

package aux_code_pkg;

   typedef enum logic [4:0] {
      ST_IDLE     = 5'h01,
      ST_WAIT_POS = 5'h02,
      ST_WAIT_ACK = 5'h04,
      ST_WAIT_REL = 5'h08,
      ST_ERROR    = 5'h10
   } aux_state_e;

   typedef enum logic {
      COORD_REFERENCE = 1'b0,
      COORD_WORKPIECE = 1'b1
   } coord_e;

   typedef logic [`AUX_CODE_W-1:0] aux_code_t;

   function automatic logic is_upper(input aux_code_t code);
      return code >= `AUX_UPPER_MIN;
   endfunction : is_upper

endpackage : aux_code_pkg

// [core/aux_code_round.sv]
`timescale 1ns/100ps
`include "aux_code_defs.svh"

module aux_code_round #(
   parameter int IW = `AUX_VAL_IW,
   parameter int FW = `AUX_VAL_FW
) (
   // Signed fixed-point value
   input  wire logic signed [IW+FW-1:0] value,
   // Rounded code and range check
   output logic             [`AUX_CODE_W-1:0] code,
   output logic                              range_err
);

   localparam logic [IW+FW:0] HALF = (IW+FW+1)'(1) << (FW-1);

   logic signed [IW+FW:0] sum;
   logic        [IW:0]    rounded;

   // Round half up; the extra sign bit keeps the add from wrapping
   assign sum     = $signed({value[IW+FW-1], value}) + $signed(HALF); // [RULE5]
   assign rounded = sum[IW+FW:FW];
   assign code    = rounded[`AUX_CODE_W-1:0];
   assign range_err = rounded[IW] || (rounded[IW-1:0] > IW'(`AUX_CODE_MAX)); // [RULE5]

endmodule : aux_code_round

// [core/aux_code_handshake.sv]
`timescale 1ns/100ps
`include "aux_code_defs.svh"

//Contract
// RULE1: Interlocking code appears after positioning completes, strobe rises same cycle.
// RULE2: Host does the code's work on strobe, acknowledges when finished.
// RULE3: Accepted acknowledge clears the code to zero and drops the strobe.
// RULE4: Host drops acknowledge after strobe; next block waits for acknowledge low. Code also releases it on termination while acknowledge is still high.
// RULE5: Code value is rounded to nearest integer; outside 0..999 is an error.
// RULE6: Codes 0..499 pause execution until the host acknowledges.
// RULE7: Codes 500..999 are presented and execution continues at once.
// RULE8: Program end clears a still-presented upper-range code and strobe.
// RULE9: Lower codes acknowledged only in automatic mode with program running.
// RULE10: Manual/automatic switching leaves code and strobe untouched.
// RULE11: Termination of a lower-code block clears its code and strobe.
// RULE12: Termination before presentation means the code is never presented.
// RULE13: Termination during acknowledge wait clears strobe and code, then continues.
// RULE14: Upper code suppressed by early termination; earlier upper code stays.
// RULE15: Reset, start, origin operations select coordinate, absolute and pass mode.
// RULE16: Host acknowledge is bit six of the second command word.
// RULE17: Strobe is reported on bit eight of the task status word.
// RULE18: Code output is ten bits, enough for 0..999.
// RULE19: Out-of-range code sets task error, stops program, presents nothing.
module aux_code_handshake #(
   parameter int IW = `AUX_VAL_IW,
   parameter int FW = `AUX_VAL_FW
) (
   // Clock and reset
   input  wire logic                    clk_sys,
   input  wire logic                    rst_n,
   // Sequencer block interface
   input  wire logic                    blk_start,
   input  wire logic signed [IW+FW-1:0] blk_code_value,
   input  wire logic                    positioned,
   input  wire logic                    opt_end_hit,
   input  wire logic                    program_end_instr,
   output logic                         block_release,
   output logic                         prog_stop,
   input  wire logic                    err_reset,
   // Operating state
   input  wire logic                    auto_mode,
   input  wire logic                    prog_running,
   // Host interface words
   input  wire logic [15:0]             cmd_word,
   output logic      [15:0]             task_status_word,
   output logic      [`AUX_CODE_W-1:0]  aux_code,
   output logic                         aux_strobe,
   // Coordinate and command state events
   input  wire logic                    main_start,
   input  wire logic                    origin_search_instr,
   input  wire logic                    reference_return_instr,
   input  wire logic                    workpiece_return_instr,
   input  wire logic                    pass_mode_instr,
   input  wire logic                    exact_mode_instr,
   input  wire logic                    abs_instr,
   input  wire logic                    incr_instr,
   output logic                         coord_workpiece,
   output logic                         cmd_incremental,
   output logic                         pass_mode
);

   aux_code_pkg::aux_state_e state_reg;
   aux_code_pkg::aux_state_e state_next;
   aux_code_pkg::aux_code_t  aux_code_reg;
   aux_code_pkg::aux_code_t  pend_code_reg;
   aux_code_pkg::aux_code_t  new_code;
   aux_code_pkg::coord_e     coord_reg;
   logic                     aux_strobe_reg;
   logic                     task_err_reg;
   logic                     release_reg;
   logic                     incr_reg;
   logic                     pass_reg;
   logic                     range_err;
   logic                     terminate;
   logic                     host_ack;
   logic                     present;
   logic                     ack_lower_ok;
   logic                     ack_accept;
   logic                     upper_drop;

   aux_code_round #(
      .IW (IW),
      .FW (FW)
   ) u_round (
      .value     (blk_code_value),
      .code      (new_code), // [RULE5]
      .range_err (range_err)
   );

   assign terminate = cmd_word[`CMD_FBE_BIT] | opt_end_hit;
   assign host_ack  = cmd_word[`CMD_ACK_BIT];
   // Lower codes only count as acknowledged while a program runs in automatic
   assign ack_lower_ok = auto_mode & prog_running; // [RULE9]
   assign present    = (state_reg == aux_code_pkg::ST_WAIT_POS) & positioned & ~terminate;
   assign ack_accept = (state_reg == aux_code_pkg::ST_WAIT_ACK) & host_ack
                       & ack_lower_ok & ~terminate; // [RULE9]
   // A presented upper code may be reset by the host in any mode
   assign upper_drop = (state_reg != aux_code_pkg::ST_WAIT_ACK) & aux_strobe_reg
                       & aux_code_pkg::is_upper(aux_code_reg)
                       & (host_ack | program_end_instr); // [RULE8] [RULE9]

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         aux_code_pkg::ST_IDLE: begin
            if (blk_start) begin
               state_next = range_err ? aux_code_pkg::ST_ERROR
                                      : aux_code_pkg::ST_WAIT_POS; // [RULE19]
            end
         end
         aux_code_pkg::ST_WAIT_POS: begin
            if (terminate) begin
               state_next = aux_code_pkg::ST_IDLE; // [RULE12] [RULE14]
            end else if (positioned) begin
               state_next = aux_code_pkg::is_upper(pend_code_reg)
                            ? aux_code_pkg::ST_IDLE        // [RULE7]
                            : aux_code_pkg::ST_WAIT_ACK;   // [RULE6]
            end
         end
         aux_code_pkg::ST_WAIT_ACK: begin
            if (terminate) begin
               state_next = aux_code_pkg::ST_IDLE; // [RULE13]
            end else if (ack_accept) begin
               state_next = aux_code_pkg::ST_WAIT_REL; // [RULE3]
            end
         end
         aux_code_pkg::ST_WAIT_REL: begin
            // Next block holds until the host lets go of its acknowledge or a termination arrives
            if (!host_ack || terminate) begin
               state_next = aux_code_pkg::ST_IDLE; // [RULE4]
            end
         end
         aux_code_pkg::ST_ERROR: begin
            if (err_reset) begin
               state_next = aux_code_pkg::ST_IDLE;
            end
         end
         default: state_next = aux_code_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_reg <= aux_code_pkg::ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pend_code_reg <= `AUX_CODE_CLEAR;
      end else if (state_reg == aux_code_pkg::ST_IDLE && blk_start && !range_err) begin
         pend_code_reg <= new_code;
      end
   end

   // Code and strobe; mode inputs act here only through ack_lower_ok in ack_accept
   always_ff @(posedge clk_sys) begin // [RULE10]
      if (!rst_n) begin
         aux_code_reg   <= `AUX_CODE_CLEAR;
         aux_strobe_reg <= 1'b0;
      end else if (present) begin
         aux_code_reg   <= pend_code_reg; // [RULE1]
         aux_strobe_reg <= 1'b1;          // [RULE1]
      end else if (ack_accept || upper_drop) begin
         aux_code_reg   <= `AUX_CODE_CLEAR; // [RULE3] [RULE8]
         aux_strobe_reg <= 1'b0;
      end else if (state_reg == aux_code_pkg::ST_WAIT_ACK && terminate) begin
         aux_code_reg   <= `AUX_CODE_CLEAR; // [RULE11] [RULE13]
         aux_strobe_reg <= 1'b0;
      end
   end

   // One-cycle go-ahead for the next block
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         release_reg <= 1'b0;
      end else begin
         release_reg <= (state_reg == aux_code_pkg::ST_WAIT_POS && (terminate || (positioned
                         && aux_code_pkg::is_upper(pend_code_reg))))           // [RULE7]
                        || (state_reg == aux_code_pkg::ST_WAIT_ACK && terminate) // [RULE13]
                        || (state_reg == aux_code_pkg::ST_WAIT_REL
                            && (!host_ack || terminate));                      // [RULE4]
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         task_err_reg <= 1'b0;
      end else if (state_reg == aux_code_pkg::ST_IDLE && blk_start && range_err) begin
         task_err_reg <= 1'b1; // [RULE19]
      end else if (err_reset) begin
         task_err_reg <= 1'b0;
      end
   end

   // Coordinate system: workpiece only after a workpiece origin return
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         coord_reg <= aux_code_pkg::COORD_REFERENCE; // [RULE15]
      end else if (workpiece_return_instr) begin
         coord_reg <= aux_code_pkg::COORD_WORKPIECE; // [RULE15]
      end else if (main_start || origin_search_instr || reference_return_instr) begin
         coord_reg <= aux_code_pkg::COORD_REFERENCE; // [RULE15]
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         incr_reg <= 1'b0;
         pass_reg <= 1'b1;
      end else if (main_start || origin_search_instr || reference_return_instr
                   || workpiece_return_instr) begin
         incr_reg <= 1'b0; // [RULE15]
         pass_reg <= 1'b1; // [RULE15]
      end else begin
         if (abs_instr) begin
            incr_reg <= 1'b0;
         end else if (incr_instr) begin
            incr_reg <= 1'b1;
         end
         if (pass_mode_instr) begin
            pass_reg <= 1'b1;
         end else if (exact_mode_instr) begin
            pass_reg <= 1'b0;
         end
      end
   end

   always_comb begin
      task_status_word                      = 16'h0000;
      task_status_word[`TSW_ERR_BIT]        = task_err_reg;
      task_status_word[`TSW_AUTO_BIT]       = auto_mode;
      task_status_word[`TSW_MANUAL_BIT]     = ~auto_mode;
      task_status_word[`TSW_RUN_BIT]        = prog_running;
      task_status_word[`TSW_WAIT_ACK_BIT]   = (state_reg == aux_code_pkg::ST_WAIT_ACK);
      task_status_word[`TSW_STROBE_BIT]     = aux_strobe_reg; // [RULE17]
   end

   assign aux_code        = aux_code_reg; // [RULE18]
   assign aux_strobe      = aux_strobe_reg;
   assign block_release   = release_reg;
   assign prog_stop       = task_err_reg; // [RULE19]
   assign coord_workpiece = (coord_reg == aux_code_pkg::COORD_WORKPIECE);
   assign cmd_incremental = incr_reg;
   assign pass_mode       = pass_reg;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   sequence s_in_wait_ack;
      state_reg == aux_code_pkg::ST_WAIT_ACK;
   endsequence

   sequence s_clear_out;
      !aux_strobe && aux_code == `AUX_CODE_CLEAR;
   endsequence

   a_present_after_pos: assert property ($rose(aux_strobe) |->
      $past(positioned) && aux_code == $past(pend_code_reg)) // [RULE1]
      else $error("strobe rose without positioning or with wrong code");

   a_ack_clears_code: assert property (s_in_wait_ack ##0 (host_ack && ack_lower_ok
      && !terminate) |=> s_clear_out ##0 !block_release) // [RULE3]
      else $error("accepted acknowledge did not clear code and strobe");

   a_wait_ack_low: assert property (state_reg == aux_code_pkg::ST_WAIT_REL
      && host_ack && !terminate |=> !block_release) // [RULE4]
      else $error("next block released while acknowledge still high");

   a_range_error: assert property (state_reg == aux_code_pkg::ST_IDLE && blk_start
      && range_err |=> task_err_reg && prog_stop && !$rose(aux_strobe)) // [RULE19]
      else $error("out-of-range code not flagged");

   a_lower_pause: assert property (s_in_wait_ack |-> !block_release
      && aux_strobe) // [RULE6]
      else $error("interlocking code did not pause execution");

   a_upper_no_wait: assert property (present && aux_code_pkg::is_upper(pend_code_reg)
      |=> block_release ##1 !block_release) // [RULE7]
      else $error("upper code did not release execution at once");

   a_prog_end_clear: assert property (state_reg == aux_code_pkg::ST_IDLE && aux_strobe
      && aux_code_pkg::is_upper(aux_code) && program_end_instr |=> s_clear_out) // [RULE8]
      else $error("program end left upper code presented");

   a_ack_ignored: assert property (s_in_wait_ack ##0 (host_ack && !ack_lower_ok
      && !terminate) |=> s_in_wait_ack ##0 aux_strobe) // [RULE9] [RULE10]
      else $error("lower code acknowledged outside automatic run");

   a_term_release: assert property (s_in_wait_ack ##0 terminate
      |=> s_clear_out ##0 block_release) // [RULE11] [RULE13]
      else $error("termination did not clear and release the wait");

   a_term_suppress: assert property (state_reg == aux_code_pkg::ST_WAIT_POS && terminate
      |=> $stable(aux_code) && $stable(aux_strobe) && block_release) // [RULE12] [RULE14]
      else $error("terminated block still changed the code outputs");

   a_workpiece_sel: assert property (workpiece_return_instr |=> coord_workpiece
      && !cmd_incremental && pass_mode) // [RULE15]
      else $error("workpiece origin return did not select workpiece state");

endmodule : aux_code_handshake

// [verif/host_ctrl_model.sv]
`timescale 1ns/100ps

module host_ctrl_model (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   // Device outputs seen by the host
   input  wire logic       aux_strobe,
   // Behaviour control from the bench
   input  wire logic       enable,
   input  wire logic [3:0] ack_delay,
   // Acknowledge back to the device
   output logic            ack
);
   logic [3:0] wait_reg;

   // The acknowledge is raised only after the code's work has taken ack_delay cycles
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ack      <= 1'b0;
         wait_reg <= 4'h0;
      end else if (!ack) begin
         if (aux_strobe && enable) begin
            if (wait_reg >= ack_delay) begin
               ack      <= 1'b1;
               wait_reg <= 4'h0;
            end else begin
               wait_reg <= wait_reg + 4'h1;
            end
         end else begin
            wait_reg <= 4'h0;
         end
      end else if (!aux_strobe) begin
         // Held until the strobe falls, then dropped late to stress the release wait
         if (wait_reg >= ack_delay) begin
            ack      <= 1'b0;
            wait_reg <= 4'h0;
         end else begin
            wait_reg <= wait_reg + 4'h1;
         end
      end
   end
endmodule : host_ctrl_model

// [verif/tb.sv]
`timescale 1ns/100ps

module tb;
   logic        clk_sys, rst_n, blk_start, positioned, auto_mode, prog_running, fbe;
   logic [23:0] blk_code_value;
   logic [10:0] ev;
   logic        host_en, host_ack, strobe_d;
   logic [3:0]  host_dly;
   logic [15:0] cmd_word, task_status_word;
   logic [9:0]  aux_code, code_a;
   logic        aux_strobe, block_release, prog_stop;
   logic        coord_workpiece, cmd_incremental, pass_mode;
   logic [31:0] seed;
   logic [9:0]  expq[$];
   int          bad_count, checks_done, cyc;

   // Acknowledge on bit 6, forced block end on bit 4
   assign cmd_word = {9'h000, host_ack, 1'b0, fbe, 4'h0};

   aux_code_handshake uut (
      .clk_sys(clk_sys), .rst_n(rst_n), .blk_start(blk_start),
      .blk_code_value(blk_code_value), .positioned(positioned), .opt_end_hit(ev[10]),
      .program_end_instr(ev[8]), .block_release(block_release), .prog_stop(prog_stop),
      .err_reset(ev[9]), .auto_mode(auto_mode), .prog_running(prog_running),
      .cmd_word(cmd_word), .task_status_word(task_status_word), .aux_code(aux_code),
      .aux_strobe(aux_strobe), .main_start(ev[0]), .origin_search_instr(ev[1]),
      .reference_return_instr(ev[2]), .workpiece_return_instr(ev[3]),
      .pass_mode_instr(ev[4]), .exact_mode_instr(ev[5]), .abs_instr(ev[6]),
      .incr_instr(ev[7]), .coord_workpiece(coord_workpiece),
      .cmd_incremental(cmd_incremental), .pass_mode(pass_mode));

   host_ctrl_model host (.clk_sys(clk_sys), .rst_n(rst_n), .aux_strobe(aux_strobe),
      .enable(host_en), .ack_delay(host_dly), .ack(host_ack));

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction : xs

   task automatic rnd();
      seed = xs(seed);
   endtask : rnd

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic nc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : nc

   task automatic pulse(input logic [10:0] m, input logic f);
      @(posedge clk_sys);
      ev  <= m;
      fbe <= f;
      @(posedge clk_sys);
      ev  <= 11'h000;
      fbe <= 1'b0;
      @(negedge clk_sys);
   endtask : pulse

   // Expected code is queued only when the block should present it
   task automatic blk(input logic [23:0] v, input logic [9:0] e, input logic pres);
      if (pres) expq.push_back(e);
      @(posedge clk_sys);
      blk_start      <= 1'b1;
      blk_code_value <= v;
      @(posedge clk_sys);
      blk_start <= 1'b0;
   endtask : blk

   task automatic wait_rel(input int lim);
      int n;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (block_release !== 1'b1 && n < lim);
      chk(block_release, 1'b1);
   endtask : wait_rel

   task automatic end_of_test();
      $display("mismatches %0d, checks %0d", bad_count, checks_done);
      if (bad_count == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : end_of_test

   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   // Every rising strobe must match the oldest queued code
   always @(posedge clk_sys) begin
      if (rst_n && aux_strobe === 1'b1 && strobe_d !== 1'b1) begin
         if (expq.size() == 0) chk({6'h00, aux_code}, 16'hFFFF);
         else chk(aux_code, expq.pop_front());
      end
      strobe_d <= aux_strobe;
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         bad_count++;
         end_of_test();
      end
   end

   initial begin
      rst_n = 1'b0; blk_start = 1'b0; blk_code_value = 24'h000000; positioned = 1'b1;
      auto_mode = 1'b1; prog_running = 1'b1; fbe = 1'b0; ev = 11'h000; host_en = 1'b0;
      host_dly = 4'h0; seed = 32'h4399; bad_count = 0; checks_done = 0; cyc = 0;
      strobe_d = 1'b0;
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      nc(1);
      chk({aux_strobe, aux_code}, 16'h0000);
      chk({coord_workpiece, cmd_incremental, pass_mode}, 3'b001);
      for (int k = 0; k < 3; k++) begin
         pulse(11'h0A0, 1'b0);
         pulse(11'h008, 1'b0);
         chk({coord_workpiece, cmd_incremental, pass_mode}, 3'b101);
         pulse(11'h0A0, 1'b0);
         chk({coord_workpiece, cmd_incremental, pass_mode}, 3'b110);
         pulse(11'h050, 1'b0);
         chk({coord_workpiece, cmd_incremental, pass_mode}, 3'b101);
         pulse(11'h001 << k, 1'b0);
         chk({coord_workpiece, cmd_incremental, pass_mode}, 3'b001);
      end
      // Non-interlocking code runs on at once, program end clears it
      rnd();
      code_a = 10'(500 + seed % 500);
      blk({6'h00, code_a, 8'h00}, code_a, 1'b1);
      wait_rel(3);
      nc(1);
      chk(task_status_word[8], 1'b1);
      pulse(11'h100, 1'b0);
      chk({aux_strobe, aux_code}, 16'h0000);
      // Interlocking code with a random fraction, slow host
      rnd();
      code_a = 10'(seed % 499);
      host_dly = {2'b10, seed[9:8]};
      host_en = 1'b1;
      blk({6'h00, code_a, seed[7:0]}, code_a + 10'(seed[7]), 1'b1);
      nc(6);
      chk({task_status_word[7], aux_strobe, block_release}, 3'b110);
      wait_rel(40);
      chk(host_ack, 1'b0);
      chk({aux_strobe, aux_code}, 16'h0000);
      // Acknowledge refused for a lower code unless a program runs in automatic mode
      // Short host delay so the refused acknowledge is really up during the check
      host_dly <= 4'h1;
      for (int k = 0; k < 2; k++) begin
         host_en <= 1'b0;
         rnd();
         code_a = 10'(seed % 500);
         blk({6'h00, code_a, 8'h00}, code_a, 1'b1);
         nc(4);
         @(posedge clk_sys);
         {auto_mode, prog_running} <= (k == 0) ? 2'b01 : 2'b10;
         host_en <= 1'b1;
         nc(10);
         chk(host_ack, 1'b1);
         chk({aux_strobe, aux_code}, {1'b1, code_a});
         chk(task_status_word, (k == 0) ? 16'h0198 : 16'h0184);
         @(posedge clk_sys);
         {auto_mode, prog_running} <= 2'b11;
         wait_rel(40);
         chk({aux_strobe, aux_code}, 16'h0000);
      end
      // Upper code acknowledged in manual mode
      host_dly <= 4'h0;
      @(posedge clk_sys);
      auto_mode <= 1'b0;
      rnd();
      code_a = 10'(500 + seed % 500);
      blk({6'h00, code_a, 8'h00}, code_a, 1'b1);
      wait_rel(3);
      nc(6);
      chk({aux_strobe, aux_code}, 16'h0000);
      @(posedge clk_sys);
      auto_mode <= 1'b1;
      // Block ended by forced end or optional end during the acknowledge wait
      host_en <= 1'b0;
      for (int k = 0; k < 2; k++) begin
         rnd();
         code_a = 10'(seed % 500);
         blk({6'h00, code_a, 8'h00}, code_a, 1'b1);
         nc(4);
         pulse((k == 1) ? 11'h400 : 11'h000, k == 0);
         wait_rel(3);
         chk({aux_strobe, aux_code}, 16'h0000);
      end
      // Block ended before presentation; an earlier upper code survives
      rnd();
      code_a = 10'(500 + seed % 500);
      blk({6'h00, code_a, 8'h00}, code_a, 1'b1);
      wait_rel(3);
      @(posedge clk_sys);
      positioned <= 1'b0;
      for (int k = 0; k < 2; k++) begin
         rnd();
         blk({6'h00, (k == 1) ? 10'(500 + seed % 500) : 10'(seed % 500), 8'h00},
             10'h000, 1'b0);
         pulse((k == 1) ? 11'h400 : 11'h000, k == 0);
         wait_rel(3);
         chk({aux_strobe, aux_code}, {1'b1, code_a});
      end
      @(posedge clk_sys);
      positioned <= 1'b1;
      pulse(11'h100, 1'b0);
      chk({aux_strobe, aux_code}, 16'h0000);
      // 999.5 rounds to 1000: error, nothing presented, new blocks refused
      blk(24'h03E780, 10'h000, 1'b0);
      nc(2);
      chk({prog_stop, task_status_word[0], aux_strobe}, 3'b110);
      blk({6'h00, 10'h258, 8'h00}, 10'h000, 1'b0);
      nc(4);
      chk({prog_stop, aux_strobe}, 2'b10);
      pulse(11'h200, 1'b0);
      chk(prog_stop, 1'b0);
      // Every queued code must have been presented by now
      chk(16'(expq.size()), 16'h0000);
      end_of_test();
   end
endmodule : tb
